//--- tb.sv
/*
 * Self-checking bench of the register bank.
 * Assumes the bus master model drives all bus pins.
 */
`timescale 1ns/1ns
`include "vacr_defs.svh"

module tb;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary value
    logic clk_sys_in, nrst_in, as_n, ds_n, wr_n, iack_n, hw_trigger_in, trig_match_in, tdc_valid_in;
    logic [31:0] addr, wdata, vme_data_out, tdc_data_in, buf_data_out, last_buf;
    logic [15:0] rotary_sw_in, buf_words_in, ev_stored_in, base;
    logic vme_data_oe_out, vme_dtack_oe_out, buf_valid_out, almost_full_out, module_reset_out;
    logic soft_clear_out, event_reset_out, trigger_out;
    logic [2:0] irq_level_out;
    logic [4:0] slot_addr_out;
    logic [7:0] events_per_block_out;
    logic [1:0] grp_ctrl_out;
    int mismatches = 0, checked = 0, n_mrst = 0, n_sclr = 0, n_evr = 0, n_trig = 0, n_buf = 0;

    vacr_regs #(.FW_REV(REV)) vacr_regs_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .vme_as_n_in(as_n), .vme_ds_n_in(ds_n), .vme_write_n_in(wr_n), .vme_iack_n_in(iack_n),
        .vme_addr_in(addr), .vme_data_in(wdata), .rotary_sw_in(rotary_sw_in),
        .vme_data_out(vme_data_out), .vme_data_oe_out(vme_data_oe_out),
        .vme_dtack_oe_out(vme_dtack_oe_out), .irq_level_out(irq_level_out),
        .hw_trigger_in(hw_trigger_in), .trig_match_in(trig_match_in), .buf_words_in(buf_words_in),
        .ev_stored_in(ev_stored_in), .tdc_data_in(tdc_data_in), .tdc_valid_in(tdc_valid_in),
        .buf_data_out(buf_data_out), .buf_valid_out(buf_valid_out), .almost_full_out(almost_full_out),
        .slot_addr_out(slot_addr_out), .events_per_block_out(events_per_block_out), .grp_ctrl_out(grp_ctrl_out),
        .module_reset_out(module_reset_out), .soft_clear_out(soft_clear_out),
        .event_reset_out(event_reset_out), .trigger_out(trigger_out));

    vacr_vme_master vacr_vme_master_i (.clk_in(clk_sys_in), .as_n_out(as_n), .ds_n_out(ds_n),
        .write_n_out(wr_n), .iack_n_out(iack_n), .addr_out(addr), .data_out(wdata),
        .dtack_oe_in(vme_dtack_oe_out), .data_in(vme_data_oe_out ? vme_data_out : 32'hFFFFFFFF));

    always @(posedge clk_sys_in) begin
        if (module_reset_out === 1'b1) n_mrst++;
        if (soft_clear_out === 1'b1) n_sclr++;
        if (event_reset_out === 1'b1) n_evr++;
        if (trigger_out === 1'b1) n_trig++;
        if (buf_valid_out === 1'b1) begin
            n_buf++;
            last_buf = buf_data_out;
        end
    end

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task automatic results;
        if (mismatches == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic iack, input logic [31:0] a, input logic [31:0] wd,
                       input logic expack, input logic [31:0] exp, input logic [31:0] m);
        logic ack;
        logic [31:0] rd;
        vacr_vme_master_i.cycle(w, iack, a, wd, ack, rd);
        chk($sformatf("ack %h", a), {31'h0, expack}, {31'h0, ack});
        if (!w && expack) chk($sformatf("data %h", a), exp, rd & m);
    endtask

    task automatic acc(input logic w, input logic [15:0] off, input logic [31:0] wd, input logic [31:0] exp);
        bus(w, 1'b0, {base, off}, wd, 1'b1, exp,
            (off == `VACR_OFF_EVCNT || off == `VACR_OFF_TESTW) ? 32'hFFFFFFFF : 32'h0000FFFF);
    endtask

    task automatic pulse(ref logic s);
        @(negedge clk_sys_in);
        s = 1'b1;
        @(negedge clk_sys_in);
        s = 1'b0;
        repeat (3) @(negedge clk_sys_in);
    endtask

    task automatic t_reset;
        acc(0, `VACR_OFF_IRQ_LVL, 0, 32'h0);
        acc(0, `VACR_OFF_IRQ_VEC, 0, 32'hDD);
        acc(0, `VACR_OFF_SLOT, 0, 32'h1F);
        acc(0, `VACR_OFF_GRP_BASE, 0, 32'hAA);
        acc(0, `VACR_OFF_THR, 0, 32'h40);
        acc(0, `VACR_OFF_BLKEV, 0, 32'h0);
        acc(0, `VACR_OFF_CTRL, 0, 32'h0);
        acc(0, `VACR_OFF_FWREV, 0, {24'h0, REV});
        acc(0, `VACR_OFF_EVST, 0, 32'h0123);
        bus(1'b0, 1'b0, {base, 16'h1040}, 32'h0, 1'b0, 32'h0, 32'h0);
    endtask

    task automatic t_fields;
        acc(1, `VACR_OFF_IRQ_LVL, 32'hFFF8, 0);
        acc(0, `VACR_OFF_IRQ_LVL, 0, 32'h0);
        acc(1, `VACR_OFF_IRQ_VEC, 32'hAB5C, 0);
        acc(0, `VACR_OFF_IRQ_VEC, 0, 32'h5C);
        acc(1, `VACR_OFF_SLOT, 32'hFFE3, 0);
        acc(0, `VACR_OFF_SLOT, 0, 32'h03);
        chk("slot out", 32'h03, {27'h0, slot_addr_out});
        acc(1, `VACR_OFF_THR, 32'h0, 0);
        acc(0, `VACR_OFF_THR, 0, 32'h1);
        acc(1, `VACR_OFF_THR, 32'hFFFF, 0);
        acc(0, `VACR_OFF_THR, 0, 32'h7FDF);
        acc(1, `VACR_OFF_BLKEV, 32'h01FF, 0);
        acc(0, `VACR_OFF_BLKEV, 0, 32'hFF);
        chk("block out", 32'hFF, {24'h0, events_per_block_out});
        bus(1'b1, 1'b0, {16'hAA00, `VACR_OFF_THR}, 32'h0123, 1'b1, 32'h0, 32'h0);
        acc(0, `VACR_OFF_THR, 0, 32'h0123);
        acc(1, `VACR_OFF_GRP_CTRL, 32'hFFFF, 0);
        bus(1'b1, 1'b0, {16'hAA00, `VACR_OFF_GRP_CTRL}, 32'h0, 1'b1, 32'h0, 32'h0);
        acc(0, `VACR_OFF_GRP_CTRL, 0, 32'h3);
        chk("group ctrl out", 32'h3, {30'h0, grp_ctrl_out});
        acc(1, `VACR_OFF_FWREV, 32'h0, 0);
        acc(0, `VACR_OFF_FWREV, 0, {24'h0, REV});
    endtask

    task automatic t_irq;
        acc(1, `VACR_OFF_THR, 32'h10, 0);
        acc(1, `VACR_OFF_IRQ_LVL, 32'h5, 0);
        buf_words_in = 16'h000F;
        repeat (3) @(negedge clk_sys_in);
        chk("almost full", 32'h0, {31'h0, almost_full_out});
        chk("irq", 32'h0, {29'h0, irq_level_out});
        buf_words_in = 16'h0010;
        repeat (3) @(negedge clk_sys_in);
        chk("almost full", 32'h1, {31'h0, almost_full_out});
        chk("irq", 32'h5, {29'h0, irq_level_out});
        bus(1'b0, 1'b1, 32'h0000000A, 32'h0, 1'b1, 32'h5C, 32'hFFFFFFFF);
        bus(1'b0, 1'b1, 32'h00000006, 32'h0, 1'b0, 32'h0, 32'h0);
        acc(1, `VACR_OFF_IRQ_LVL, 32'h0, 0);
        repeat (3) @(negedge clk_sys_in);
        chk("irq", 32'h0, {29'h0, irq_level_out});
        buf_words_in = 16'h0000;
    endtask

    task automatic t_strobes;
        trig_match_in = 1'b1;
        acc(1, `VACR_OFF_SCLR, 32'h0, 0);
        chk("clear pulses", 32'd1, n_sclr);
        acc(1, `VACR_OFF_STRG, 32'h0, 0);
        acc(1, `VACR_OFF_STRG, 32'h0, 0);
        chk("trigger pulses", 32'd2, n_trig);
        pulse(hw_trigger_in);
        chk("trigger pulses", 32'd3, n_trig);
        acc(0, `VACR_OFF_EVCNT, 0, 32'd3);
        trig_match_in = 1'b0;
        acc(1, `VACR_OFF_STRG, 32'h0, 0);
        acc(0, `VACR_OFF_EVCNT, 0, 32'd3);
        acc(1, `VACR_OFF_SEVR, 32'h0, 0);
        chk("event reset pulses", 32'd1, n_evr);
        acc(1, `VACR_OFF_SCLR, 32'h0, 0);
        acc(0, `VACR_OFF_EVCNT, 0, 32'd0);
        acc(0, `VACR_OFF_MOD_RST, 0, 32'h0);
        chk("module reset pulses", 32'd1, n_mrst);
        acc(0, `VACR_OFF_SLOT, 0, 32'h1F);
        acc(0, `VACR_OFF_THR, 0, 32'h40);
    endtask

    task automatic t_test;
        acc(1, `VACR_OFF_CTRL, 32'h1, 0);
        acc(0, `VACR_OFF_CTRL, 0, 32'h1);
        acc(1, `VACR_OFF_TESTW, 32'h89ABCDEF, 0);
        chk("buffer words", 32'd1, n_buf);
        chk("buffer data", 32'h89ABCDEF, last_buf);
        tdc_data_in = 32'h13579BDF;
        pulse(tdc_valid_in);
        chk("buffer words", 32'd1, n_buf);
        acc(1, `VACR_OFF_CTRL, 32'h0, 0);
        pulse(tdc_valid_in);
        chk("buffer data", 32'h13579BDF, last_buf);
    endtask

    task automatic t_reloc;
        acc(1, `VACR_OFF_RELOC_HI, 32'h12, 0);
        acc(0, `VACR_OFF_RELOC_HI, 0, 32'h12);
        acc(1, `VACR_OFF_RELOC_LO, 32'h34, 0);
        acc(0, `VACR_OFF_RELOC_LO, 0, 32'h34);
        acc(1, `VACR_OFF_RELOC_SEL, 32'h1, 0);
        base = 16'h1234;
        bus(1'b0, 1'b0, {16'h00EE, `VACR_OFF_SLOT}, 32'h0, 1'b0, 32'h0, 32'h0);
        acc(0, `VACR_OFF_SLOT, 0, 32'h1F);
        acc(1, `VACR_OFF_RELOC_SEL, 32'h0, 0);
        base = 16'h00EE;
        acc(0, `VACR_OFF_RELOC_SEL, 0, 32'h0);
    endtask

    initial begin
        nrst_in = 1'b0;
        hw_trigger_in = 1'b0;
        trig_match_in = 1'b0;
        tdc_valid_in = 1'b0;
        tdc_data_in = 32'h0;
        buf_words_in = 16'h0;
        ev_stored_in = 16'h0123;
        rotary_sw_in = 16'h00EE;
        base = 16'h00EE;
        repeat (10) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        t_reset;
        t_fields;
        t_irq;
        t_strobes;
        t_test;
        t_reloc;
        results;
    end

    // About 60 bus cycles of under 30 clocks each
    initial begin
        #100000;
        mismatches++;
        results;
    end
endmodule

//--- vacr_defs.svh
/*
 * Offsets, field positions, reset values and limits of the acquisition register bank.
 * Assumes inclusion by bare name from the bank's design file.
 */
`ifndef VACR_DEFS_SVH
`define VACR_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define VACR_OFF_CTRL 16'h1000
`define VACR_OFF_RELOC_HI 16'h1004
`define VACR_OFF_RELOC_LO 16'h1006
`define VACR_OFF_RELOC_SEL 16'h1008
`define VACR_OFF_IRQ_LVL 16'h100A
`define VACR_OFF_IRQ_VEC 16'h100C
`define VACR_OFF_SLOT 16'h100E
`define VACR_OFF_GRP_BASE 16'h1010
`define VACR_OFF_GRP_CTRL 16'h1012
`define VACR_OFF_MOD_RST 16'h1014
`define VACR_OFF_SCLR 16'h1016
`define VACR_OFF_SEVR 16'h1018
`define VACR_OFF_STRG 16'h101A
`define VACR_OFF_EVCNT 16'h101C
`define VACR_OFF_EVST 16'h1020
`define VACR_OFF_THR 16'h1022
`define VACR_OFF_BLKEV 16'h1024
`define VACR_OFF_FWREV 16'h1026
`define VACR_OFF_TESTW 16'h1028

// ****************************************
// Field positions, reset values and threshold limits
// ****************************************
`define VACR_CTRL_TEST_BIT 0
`define VACR_IRQ_LVL_RST 3'h0
`define VACR_IRQ_VEC_RST 8'hDD
`define VACR_SLOT_RST 5'h1F
`define VACR_GRP_BASE_RST 8'hAA
`define VACR_GRP_CTRL_RST 2'h0
`define VACR_THR_RST 16'h0040
`define VACR_THR_MIN 16'h0001
`define VACR_THR_MAX 16'h7FDF
`define VACR_BLKEV_RST 8'h00

`endif

//--- vacr_pkg.sv
/*
 * Types shared by the acquisition register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vacr_pkg;

    // Bus slave cycle state
    typedef enum logic [0:0] {
        VACR_IDLE,
        VACR_HOLD
    } vacr_state_t;

endpackage

//--- vacr_regs.sv
/*
 * VME-side control and status register bank of a multi-channel TDC acquisition board.
 * Assumes the VME pins arrive unsynchronised, the master holds address and data stable
 * while its strobes are low, and trigger, buffer and converter signals are on clk_sys_in.
 */
`timescale 1ns/1ns
`include "vacr_defs.svh"

module vacr_regs #(
    parameter logic [7:0] FW_REV = 8'h00  // Arbitrary value
) (
    input wire logic clk_sys_in,          // System clock 100 MHz
    input wire logic nrst_in,             // Async reset, active low
    input wire logic vme_as_n_in,         // Address strobe, low active
    input wire logic vme_ds_n_in,         // Data strobe, low active
    input wire logic vme_write_n_in,      // Low for write
    input wire logic vme_iack_n_in,       // Interrupt acknowledge, low active
    input wire logic [31:0] vme_addr_in,  // Address lines
    input wire logic [31:0] vme_data_in,  // Data lines in
    input wire logic [15:0] rotary_sw_in, // Base address switches
    output logic [31:0] vme_data_out,     // Data lines out
    output logic vme_data_oe_out,         // Data drive enable
    output logic vme_dtack_oe_out,        // Pull acknowledge low
    output logic [2:0] irq_level_out,     // Requested level, 0 idle
    input wire logic hw_trigger_in,       // Hardware trigger pulse
    input wire logic trig_match_in,       // Trigger matching mode
    input wire logic [15:0] buf_words_in, // Buffer word count
    input wire logic [15:0] ev_stored_in, // Events in buffer
    input wire logic [31:0] tdc_data_in,  // Converter data word
    input wire logic tdc_valid_in,        // Converter data valid
    output logic [31:0] buf_data_out,     // Buffer write data
    output logic buf_valid_out,           // Buffer write pulse
    output logic almost_full_out,         // Threshold reached
    output logic [4:0] slot_addr_out,     // Slot for header/trailer
    output logic [7:0] events_per_block_out, // Block event count
    output logic [1:0] grp_ctrl_out,      // Group transfer settings
    output logic module_reset_out,        // One-shot board reset
    output logic soft_clear_out,          // Clear converters, buffer
    output logic event_reset_out,         // Converter event reset
    output logic trigger_out              // Trigger to converters
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [3:0] ctl_m_r;
    logic [3:0] ctl_s_r;
    logic [31:0] addr_m_r;
    logic [31:0] addr_s_r;
    logic [31:0] din_m_r;
    logic [31:0] din_s_r;
    logic [15:0] sw_m_r;
    logic [15:0] sw_s_r;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ctl_m_r <= 4'hF;
            ctl_s_r <= 4'hF;
            addr_m_r <= 32'h0;
            addr_s_r <= 32'h0;
            din_m_r <= 32'h0;
            din_s_r <= 32'h0;
            sw_m_r <= 16'h0;
            sw_s_r <= 16'h0;
        end else begin
            ctl_m_r <= {vme_as_n_in, vme_ds_n_in, vme_write_n_in, vme_iack_n_in};
            ctl_s_r <= ctl_m_r;
            addr_m_r <= vme_addr_in;
            addr_s_r <= addr_m_r;
            din_m_r <= vme_data_in;
            din_s_r <= din_m_r;
            sw_m_r <= rotary_sw_in;
            sw_s_r <= sw_m_r;
        end
    end

    // ****************************************
    // Registers and decode
    // ****************************************
    vacr_pkg::vacr_state_t state_r;
    logic [7:0] reloc_hi_r;
    logic [7:0] reloc_lo_r;
    logic reloc_sel_r;
    logic [2:0] irq_lvl_r;
    logic [7:0] irq_vec_r;
    logic [4:0] slot_r;
    logic [7:0] grp_base_r;
    logic [1:0] grp_ctrl_r;
    logic [15:0] thr_r;
    logic [7:0] blkev_r;
    logic test_mode_r;
    logic [31:0] test_word_r;
    logic [31:0] ev_cnt_r;
    logic [31:0] rd_data;
    logic rd_hit;

    wire as_s = ~ctl_s_r[3];
    wire ds_s = ~ctl_s_r[2];
    wire wr_s = ~ctl_s_r[1];
    wire iack_s = ~ctl_s_r[0];
    wire [15:0] off = addr_s_r[15:0];
    wire start = (state_r == vacr_pkg::VACR_IDLE) && as_s && ds_s;
    // Old switch base no longer answers once relocation is on; slot is untouched
    wire own_hit = reloc_sel_r ? (addr_s_r[31:16] == {reloc_hi_r, reloc_lo_r})
                               : (addr_s_r[31:16] == sw_s_r);
    wire grp_hit = addr_s_r[31:24] == grp_base_r;
    wire acc = start && !iack_s && own_hit;
    wire wr_acc = acc && wr_s;
    wire grp_wr = start && !iack_s && wr_s && grp_hit && !own_hit;
    // Acknowledge answered only when our level is the one being served
    wire iack_hit = start && iack_s && (irq_lvl_r != 3'h0) && (addr_s_r[3:1] == irq_lvl_r);
    wire soft_rst = module_reset_out;

    function automatic logic wr_at(input logic [15:0] o, input logic [15:0] target);
        wr_at = wr_acc && (o == target);
    endfunction

    wire test_push = wr_at(off, `VACR_OFF_TESTW) && test_mode_r;
    wire cnt_clr = soft_rst || soft_clear_out;

    always_comb begin
        rd_data = 32'h0;
        rd_hit = 1'b1;
        unique case (off)
            `VACR_OFF_CTRL: rd_data[`VACR_CTRL_TEST_BIT] = test_mode_r;
            `VACR_OFF_RELOC_HI: rd_data[7:0] = reloc_hi_r;
            `VACR_OFF_RELOC_LO: rd_data[7:0] = reloc_lo_r;
            `VACR_OFF_IRQ_LVL: rd_data[2:0] = irq_lvl_r;
            `VACR_OFF_IRQ_VEC: rd_data[7:0] = irq_vec_r;
            `VACR_OFF_SLOT: rd_data[4:0] = slot_r;
            `VACR_OFF_GRP_BASE: rd_data[7:0] = grp_base_r;
            `VACR_OFF_GRP_CTRL: rd_data[1:0] = grp_ctrl_r;
            `VACR_OFF_EVCNT: rd_data = ev_cnt_r;
            `VACR_OFF_EVST: rd_data[15:0] = ev_stored_in;
            `VACR_OFF_THR: rd_data[15:0] = thr_r;
            `VACR_OFF_BLKEV: rd_data[7:0] = blkev_r;
            `VACR_OFF_FWREV: rd_data[7:0] = FW_REV;
            `VACR_OFF_TESTW: rd_data = test_word_r;
            // Relocation select and strobe locations answer a read with zero data
            `VACR_OFF_RELOC_SEL, `VACR_OFF_MOD_RST, `VACR_OFF_SCLR,
            `VACR_OFF_SEVR, `VACR_OFF_STRG: rd_data = 32'h0;
            default: rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // Bus slave cycle
    // ****************************************
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= vacr_pkg::VACR_IDLE;
            vme_data_out <= 32'h0;
            vme_data_oe_out <= 1'b0;
            vme_dtack_oe_out <= 1'b0;
        end else begin
            unique case (state_r)
                vacr_pkg::VACR_IDLE: begin
                    if (start) begin
                        state_r <= vacr_pkg::VACR_HOLD;
                        if (iack_hit) begin
                            vme_data_out <= {24'h0, irq_vec_r};
                            vme_data_oe_out <= 1'b1;
                            vme_dtack_oe_out <= 1'b1;
                        end else if (acc && rd_hit) begin
                            vme_data_out <= wr_s ? 32'h0 : rd_data;
                            vme_data_oe_out <= !wr_s;
                            vme_dtack_oe_out <= 1'b1;
                        end else if (grp_wr) begin
                            vme_dtack_oe_out <= 1'b1;
                        end
                    end
                end
                vacr_pkg::VACR_HOLD: begin
                    if (!ds_s) begin
                        state_r <= vacr_pkg::VACR_IDLE;
                        vme_data_oe_out <= 1'b0;
                        vme_dtack_oe_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Address and interrupt setup
    // ****************************************
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reloc_hi_r <= 8'h0;
            reloc_lo_r <= 8'h0;
            reloc_sel_r <= 1'b0;
            irq_lvl_r <= `VACR_IRQ_LVL_RST;
            irq_vec_r <= `VACR_IRQ_VEC_RST;
            slot_r <= `VACR_SLOT_RST;
            grp_base_r <= `VACR_GRP_BASE_RST;
            grp_ctrl_r <= `VACR_GRP_CTRL_RST;
        end else if (soft_rst) begin
            reloc_sel_r <= 1'b0;
            irq_lvl_r <= `VACR_IRQ_LVL_RST;
            irq_vec_r <= `VACR_IRQ_VEC_RST;
            slot_r <= `VACR_SLOT_RST;
            grp_ctrl_r <= `VACR_GRP_CTRL_RST;
        end else begin
            if (wr_at(off, `VACR_OFF_RELOC_HI))
                reloc_hi_r <= din_s_r[7:0];
            if (wr_at(off, `VACR_OFF_RELOC_LO))
                reloc_lo_r <= din_s_r[7:0];
            if (wr_at(off, `VACR_OFF_RELOC_SEL))
                reloc_sel_r <= din_s_r[0];
            if (wr_at(off, `VACR_OFF_IRQ_LVL))
                irq_lvl_r <= din_s_r[2:0];
            if (wr_at(off, `VACR_OFF_IRQ_VEC))
                irq_vec_r <= din_s_r[7:0];
            if (wr_at(off, `VACR_OFF_SLOT))
                slot_r <= din_s_r[4:0];
            if (wr_at(off, `VACR_OFF_GRP_BASE))
                grp_base_r <= din_s_r[7:0];
            if (wr_at(off, `VACR_OFF_GRP_CTRL))
                grp_ctrl_r <= din_s_r[1:0];
        end
    end

    // ****************************************
    // Readout setup, threshold and block count group writable
    // ****************************************
    wire thr_wr = wr_at(off, `VACR_OFF_THR) || (grp_wr && off == `VACR_OFF_THR);
    wire blk_wr = wr_at(off, `VACR_OFF_BLKEV) || (grp_wr && off == `VACR_OFF_BLKEV);

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            thr_r <= `VACR_THR_RST;
            blkev_r <= `VACR_BLKEV_RST;
            test_mode_r <= 1'b0;
            test_word_r <= 32'h0;
        end else if (soft_rst) begin
            thr_r <= `VACR_THR_RST;
            blkev_r <= `VACR_BLKEV_RST;
            test_mode_r <= 1'b0;
        end else begin
            // Out-of-range thresholds are clamped, so the flag can never be stuck
            if (thr_wr) begin
                if (din_s_r[15:0] < `VACR_THR_MIN)
                    thr_r <= `VACR_THR_MIN;
                else if (din_s_r[15:0] > `VACR_THR_MAX)
                    thr_r <= `VACR_THR_MAX;
                else
                    thr_r <= din_s_r[15:0];
            end
            if (blk_wr)
                blkev_r <= din_s_r[7:0];
            if (wr_at(off, `VACR_OFF_CTRL))
                test_mode_r <= din_s_r[`VACR_CTRL_TEST_BIT];
            if (wr_at(off, `VACR_OFF_TESTW))
                test_word_r <= din_s_r;
        end
    end

    // ****************************************
    // Command strobes and trigger counter
    // ****************************************
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            module_reset_out <= 1'b0;
            soft_clear_out <= 1'b0;
            event_reset_out <= 1'b0;
            trigger_out <= 1'b0;
        end else begin
            module_reset_out <= acc && (off == `VACR_OFF_MOD_RST);
            soft_clear_out <= wr_at(off, `VACR_OFF_SCLR);
            event_reset_out <= wr_at(off, `VACR_OFF_SEVR);
            trigger_out <= hw_trigger_in || wr_at(off, `VACR_OFF_STRG);
        end
    end

    // A trigger in the clearing cycle is kept, the count restarts at one
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in)
            ev_cnt_r <= 32'h0;
        else if (cnt_clr)
            ev_cnt_r <= {31'h0, trigger_out && trig_match_in};
        else if (trigger_out && trig_match_in)
            ev_cnt_r <= ev_cnt_r + 32'h1;
    end

    // ****************************************
    // Buffer feed and status outputs
    // ****************************************
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            buf_data_out <= 32'h0;
            buf_valid_out <= 1'b0;
            almost_full_out <= 1'b0;
            irq_level_out <= 3'h0;
            slot_addr_out <= `VACR_SLOT_RST;
            events_per_block_out <= `VACR_BLKEV_RST;
            grp_ctrl_out <= `VACR_GRP_CTRL_RST;
        end else begin
            if (test_mode_r) begin
                buf_valid_out <= test_push;
                buf_data_out <= din_s_r;
            end else begin
                buf_valid_out <= tdc_valid_in;
                buf_data_out <= tdc_data_in;
            end
            almost_full_out <= buf_words_in >= thr_r;
            irq_level_out <= (buf_words_in >= thr_r) ? irq_lvl_r : 3'h0;
            slot_addr_out <= slot_r;
            events_per_block_out <= blkev_r;
            grp_ctrl_out <= grp_ctrl_r;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_vector_on_iack;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        $rose(vme_dtack_oe_out) && iack_s |-> vme_data_out == {24'h0, irq_vec_r};
    endproperty
    a_vector_on_iack: assert property (p_vector_on_iack) else $error("Wrong vector on acknowledge");

    property p_reloc_decode;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        $rose(vme_dtack_oe_out) && !iack_s && $past(reloc_sel_r) && !$past(grp_wr)
            |-> addr_s_r[31:16] == {$past(reloc_hi_r), $past(reloc_lo_r)};
    endproperty
    a_reloc_decode: assert property (p_reloc_decode) else $error("Answered off relocated base");

    property p_irq_gated;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        irq_level_out != 3'h0 |-> almost_full_out && irq_level_out == $past(irq_lvl_r);
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("Request without almost full");

    property p_thr_range;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        thr_r >= `VACR_THR_MIN && thr_r <= `VACR_THR_MAX;
    endproperty
    a_thr_range: assert property (p_thr_range) else $error("Threshold out of range");

    property p_count_mode;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        !trig_match_in && !cnt_clr |=> $stable(ev_cnt_r);
    endproperty
    a_count_mode: assert property (p_count_mode) else $error("Counter moved outside matching");

    property p_clear_counter;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        soft_clear_out |=> ev_cnt_r <= 32'h1;
    endproperty
    a_clear_counter: assert property (p_clear_counter) else $error("Clear left counter");

    property p_test_block;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        buf_valid_out && $past(test_mode_r) |-> $past(test_push) && buf_data_out == $past(din_s_r);
    endproperty
    a_test_block: assert property (p_test_block) else $error("Buffer fed outside test word");

    property p_reset_one_shot;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        module_reset_out |=> !module_reset_out ##1 thr_r == `VACR_THR_RST;
    endproperty
    a_reset_one_shot: assert property (p_reset_one_shot) else $error("Module reset not one shot");

    property p_soft_trigger;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        wr_acc && off == `VACR_OFF_STRG |=> trigger_out;
    endproperty
    a_soft_trigger: assert property (p_soft_trigger) else $error("Soft trigger lost");

    property p_dtack_release;
        @(posedge clk_sys_in) disable iff (!nrst_in)
        state_r == vacr_pkg::VACR_HOLD && !ds_s |=> !vme_dtack_oe_out && !vme_data_oe_out;
    endproperty
    a_dtack_release: assert property (p_dtack_release) else $error("Acknowledge held after strobe");

endmodule

//--- vacr_vme_master.sv
/*
 * Behavioural bus master that faces the acquisition register bank.
 * Assumes one clock; the testbench calls cycle() hierarchically.
 */
`timescale 1ns/1ns

module vacr_vme_master (
    input wire logic clk_in,           // System clock
    output logic as_n_out,             // Address strobe
    output logic ds_n_out,             // Data strobe
    output logic write_n_out,          // Low for write
    output logic iack_n_out,           // Acknowledge cycle
    output logic [31:0] addr_out,      // Address lines
    output logic [31:0] data_out,      // Data lines
    input wire logic dtack_oe_in,      // Slave acknowledge
    input wire logic [31:0] data_in    // Slave data
);
    // Idle lines show the inverse of the last value, never a stale copy
    initial begin
        as_n_out = 1'b1;
        ds_n_out = 1'b1;
        write_n_out = 1'b1;
        iack_n_out = 1'b1;
        addr_out = 32'h0;
        data_out = 32'h0;
    end

    // ack low means no acknowledge came within the bound
    task automatic cycle(input logic wr, input logic iack, input logic [31:0] addr,
                         input logic [31:0] wd, output logic ack, output logic [31:0] rd);
        int n = 0;
        ack = 1'b0;
        rd = 32'h0;
        @(negedge clk_in);
        addr_out = addr;
        data_out = wr ? wd : ~wd;
        write_n_out = ~wr;
        iack_n_out = ~iack;
        as_n_out = 1'b0;
        ds_n_out = 1'b0;
        while (!ack && n < 12) begin
            @(posedge clk_in);
            n++;
            if (dtack_oe_in === 1'b1) begin
                ack = 1'b1;
                rd = data_in;
            end
        end
        @(negedge clk_in);
        as_n_out = 1'b1;
        ds_n_out = 1'b1;
        write_n_out = 1'b1;
        iack_n_out = 1'b1;
        addr_out = ~addr;
        data_out = ~data_out;
        n = 0;
        while (dtack_oe_in !== 1'b0 && n < 12) begin
            @(posedge clk_in);
            n++;
        end
        @(negedge clk_in);
    endtask
endmodule
